// ---- hw/irq_unit_pkg.sv ----
// Constants shared by the vectored interrupt unit and its picker.
// Assumes a byte-wide special-register bus and a 20 MHz system clock.
package irq_unit_pkg;

  // Register map and field positions
  localparam logic [7:0] PRIMARY_MASK_ADDR = 8'hA8;
  localparam logic [7:0] PRIMARY_MASK_RESET = 8'h00;
  localparam int GLOBAL_GATE_BIT = 7;
  localparam int SPI_MASK_BIT = 6;
  localparam int TIMER2_MASK_BIT = 5;
  localparam int SERIAL_MASK_BIT = 4;
  localparam int TIMER1_MASK_BIT = 3;
  localparam int LINE1_MASK_BIT = 2;
  localparam int TIMER0_MASK_BIT = 1;
  localparam int LINE0_MASK_BIT = 0;
  localparam int PORT_COMPARE_EXT_BIT = 1;

  // Sources and vectors
  localparam int NUM_SOURCES = 15;
  localparam int ORDER_W = 4;
  localparam int PRIMARY_SOURCES = 7;
  localparam logic [3:0] PORT_COMPARE_ORDER = 4'h8;
  localparam logic [3:0] HW_CLEAR_LIMIT = 4'h4;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam int VECTOR_SHIFT = 3;
  localparam logic [15:0] LAST_VECTOR = 16'h0073;

  // Latency figures, in system clocks of 50 ns
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int DETECT_CYCLES = 1;
  localparam int LONG_CALL_CYCLES = 4;
  localparam int RETURN_CYCLES = 5;
  localparam int DIVIDE_CYCLES = 8;
  localparam int MIN_LATENCY_CYCLES = DETECT_CYCLES + LONG_CALL_CYCLES;
  localparam int MAX_LATENCY_CYCLES =
    DETECT_CYCLES + RETURN_CYCLES + DIVIDE_CYCLES + LONG_CALL_CYCLES;

endpackage

// ---- hw/lowest_order_pick.sv ----
// Fixed-order picker: lowest set index wins.
// Assumes requests are already masked; purely combinational.
`timescale 1ns/1ps

module lowest_order_pick #(
  parameter int N = 15,
  parameter int W = 4
) (
  // Requests
  input wire logic [N-1:0] req_in,
  // Result
  output logic found_out,
  output logic [W-1:0] index_out
);

  always_comb begin
    found_out = 1'b0;
    index_out = '0;
    // Scan downward so the lowest order is the last to land
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        found_out = 1'b1;
        index_out = W'(i);
      end
    end
  end

endmodule

// ---- hw/two_level_vectored_interrupt_unit.sv ----
// Two-level vectored interrupt unit: enable register, priority decode,
// vector request to the core and service context tracking.
// Assumes pending flags live in the peripherals, are synchronous to
// clock_in, and that the core reports boundaries and returns.
//
// Functional notes
// - Sample and decode all pending flags every cycle
// - Minimum latency five clocks: detect plus call
// - One instruction completes after return before call
// - Worst case eighteen clocks including return and divide
// - Equal or higher routine running blocks new request
// - On exit, highest priority pending request goes next
// - Reset vectors zero; sources at 0x0003 plus 8n
// - Only line and timer0/1 flags cleared by hardware
// - Global gate bit 7 overrides every mask
// - Mask bit zero suppresses that source's request
// - Bit 6 masks SPI, vector 0x0033
// - Bit 5 masks timer 2, vector 0x002B
// - Bit 4 masks serial port, vector 0x0023
// - Bit 3 masks timer 1, vector 0x001B
// - Bit 2 masks external line one, vector 0x0013
// - Bit 1 masks timer 0, vector 0x000B
// - High preempts low; high never preempted
// - Same cycle: higher level, then lower order wins
// - Flag set regardless of mask; re-requests after return
// - Software-set flag behaves as genuine request
`timescale 1ns/1ps

module two_level_vectored_interrupt_unit
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Special-register bus
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  // Sources and their configuration
  input wire logic [irq_unit_pkg::NUM_SOURCES-1:0] pending_in,
  input wire logic [irq_unit_pkg::NUM_SOURCES-1:0] priority_in,
  input wire logic [7:0] extended_mask_register_in,
  output logic [irq_unit_pkg::NUM_SOURCES-1:0] hw_clear_out,
  // Core side
  input wire logic instr_boundary_in,
  input wire logic return_from_service_in,
  output logic call_req_out,
  output logic [15:0] vector_out,
  output logic [1:0] service_level_out
);
  import irq_unit_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Primary mask register

  logic [7:0] primary_mask_register_reg;
  logic [7:0] primary_mask_register_next;
  logic [7:0] sfr_rdata_reg;
  logic [7:0] sfr_rdata_next;
  logic reg_hit;

  assign reg_hit = (sfr_addr_in == PRIMARY_MASK_ADDR);

  always_comb begin
    primary_mask_register_next = primary_mask_register_reg;
    sfr_rdata_next = 8'h00;
    if (sfr_wr_in && reg_hit) begin
      primary_mask_register_next = sfr_wdata_in;
    end
    // Other addresses belong to other blocks, so read back zero here
    if (sfr_rd_in && reg_hit) begin
      sfr_rdata_next = primary_mask_register_reg;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      primary_mask_register_reg <= PRIMARY_MASK_RESET;
      sfr_rdata_reg <= 8'h00;
    end else begin
      primary_mask_register_reg <= primary_mask_register_next;
      sfr_rdata_reg <= sfr_rdata_next;
    end
  end

  assign sfr_rdata_out = sfr_rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Masking and priority decode, every cycle

  logic global_irq_gate;
  logic [NUM_SOURCES-1:0] enable_vec;
  logic [NUM_SOURCES-1:0] masked_req;
  logic [NUM_SOURCES-1:0] high_req;
  logic [NUM_SOURCES-1:0] low_req;
  logic hi_found;
  logic lo_found;
  logic [ORDER_W-1:0] hi_index;
  logic [ORDER_W-1:0] lo_index;

  assign global_irq_gate = primary_mask_register_reg[GLOBAL_GATE_BIT];
  // Orders 0..6 from the primary register, 7..14 from the extended one
  assign enable_vec = {extended_mask_register_in,
                       primary_mask_register_reg[PRIMARY_SOURCES-1:0]};
  // Flags come in regardless of masks; written or real, they count alike
  assign masked_req = pending_in & enable_vec & {NUM_SOURCES{global_irq_gate}};
  assign high_req = masked_req & priority_in;
  assign low_req = masked_req & ~priority_in;

  lowest_order_pick #(.N(NUM_SOURCES), .W(ORDER_W)) high_pick (
    .req_in(high_req),
    .found_out(hi_found),
    .index_out(hi_index)
  );

  lowest_order_pick #(.N(NUM_SOURCES), .W(ORDER_W)) low_pick (
    .req_in(low_req),
    .found_out(lo_found),
    .index_out(lo_index)
  );

  ////////////////////////////////////////////////////////////////////////
  // Winner selection against the running service context

  logic active_low_reg;
  logic active_high_reg;
  logic win_valid;
  logic win_high;
  logic [ORDER_W-1:0] win_index;

  always_comb begin
    win_valid = 1'b0;
    win_high = 1'b0;
    win_index = '0;
    if (!active_high_reg) begin
      if (hi_found) begin
        win_valid = 1'b1;
        win_high = 1'b1;
        win_index = hi_index;
      end else if (lo_found && !active_low_reg) begin
        win_valid = 1'b1;
        win_index = lo_index;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Vector request, context and hardware clears

  logic call_req_reg;
  logic call_req_next;
  logic win_high_reg;
  logic win_high_next;
  logic [ORDER_W-1:0] win_order_reg;
  logic [ORDER_W-1:0] win_order_next;
  logic [15:0] vector_reg;
  logic [15:0] vector_next;
  logic active_low_next;
  logic active_high_next;
  logic [NUM_SOURCES-1:0] hw_clear_reg;
  logic [NUM_SOURCES-1:0] hw_clear_next;
  logic take;

  // The return's own completion is no boundary, so exactly one more
  // instruction runs before a pending call is accepted
  assign take = call_req_reg && instr_boundary_in && !return_from_service_in;

  always_comb begin
    active_low_next = active_low_reg;
    active_high_next = active_high_reg;
    hw_clear_next = '0;
    if (take) begin
      if (win_high_reg) begin
        active_high_next = 1'b1;
      end else begin
        active_low_next = 1'b1;
      end
      if (win_order_reg < HW_CLEAR_LIMIT) begin
        hw_clear_next[win_order_reg] = 1'b1;
      end
    end else if (return_from_service_in) begin
      // Return closes the innermost routine first
      if (active_high_reg) begin
        active_high_next = 1'b0;
      end else begin
        active_low_next = 1'b0;
      end
    end
  end

  always_comb begin
    // One clock of detection, then the core spends the call cycles
    call_req_next = win_valid && !take;
    win_high_next = win_high;
    win_order_next = win_index;
    vector_next = VECTOR_BASE + (16'(win_index) << VECTOR_SHIFT);
    if (!call_req_next) begin
      win_high_next = win_high_reg;
      win_order_next = win_order_reg;
      vector_next = vector_reg;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      call_req_reg <= 1'b0;
      win_high_reg <= 1'b0;
      win_order_reg <= '0;
      vector_reg <= RESET_VECTOR;
      active_low_reg <= 1'b0;
      active_high_reg <= 1'b0;
      hw_clear_reg <= '0;
    end else begin
      call_req_reg <= call_req_next;
      win_high_reg <= win_high_next;
      win_order_reg <= win_order_next;
      vector_reg <= vector_next;
      active_low_reg <= active_low_next;
      active_high_reg <= active_high_next;
      hw_clear_reg <= hw_clear_next;
    end
  end

  assign call_req_out = call_req_reg;
  assign vector_out = vector_reg;
  assign hw_clear_out = hw_clear_reg;
  assign service_level_out = {active_high_reg, active_low_reg};

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_detect_next_cycle: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (win_valid && !take && !return_from_service_in) |=> call_req_out
  ) else $error("serviceable request not raised one cycle later");

  a_vector_in_range: assert property (
    @(posedge clock_in) disable iff (rst_in)
    call_req_out |-> (vector_out == VECTOR_BASE + (16'(win_order_reg) << VECTOR_SHIFT))
      && (vector_out <= LAST_VECTOR)
  ) else $error("vector does not match the winning order");

  a_hw_clear_cause: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (hw_clear_out != '0) |-> $past(take) && ($past(win_order_reg) < HW_CLEAR_LIMIT)
      && (hw_clear_out[NUM_SOURCES-1:4] == '0)
  ) else $error("hardware clear without a matching vector take");

  a_hw_clear_given: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (take && win_order_reg < HW_CLEAR_LIMIT) |=> $onehot(hw_clear_out)
  ) else $error("low-order flag not cleared on vectoring");

  a_gate_blocks_all: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (!global_irq_gate) [*2] |-> !call_req_out
  ) else $error("request raised with global gate closed");

  a_mask_honoured: assert property (
    @(posedge clock_in) disable iff (rst_in)
    $rose(call_req_out) |->
      ((($past(masked_req) >> win_order_reg) & 15'h0001) != 15'h0000)
  ) else $error("request raised for a masked source");

  a_high_not_preempted: assert property (
    @(posedge clock_in) disable iff (rst_in)
    active_high_reg |-> !call_req_out
  ) else $error("request raised during a high-level routine");

  a_low_only_high_preempts: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (active_low_reg && call_req_out) |-> win_high_reg
  ) else $error("low request raised during a low-level routine");

  a_level_order_win: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ($rose(call_req_out) && !win_high_reg) |-> ($past(high_req) == '0)
  ) else $error("low level chosen over a pending high request");

  a_return_pops: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (return_from_service_in && active_high_reg) |=>
      (!active_high_reg && active_low_reg == $past(active_low_reg))
  ) else $error("return did not close the high-level routine");

  a_take_drops_request: assert property (
    @(posedge clock_in) disable iff (rst_in)
    take |=> (!call_req_out && (service_level_out != 2'h0))
  ) else $error("taken request still raised or no routine opened");

  a_return_closes_low: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (return_from_service_in && !active_high_reg) |=> !active_low_reg
  ) else $error("return did not close the low-level routine");

  a_clear_single_pulse: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (hw_clear_out != '0) |=> (hw_clear_out == '0)
  ) else $error("hardware clear held longer than one cycle");

endmodule

// ---- tb/core_model.sv ----
// Behavioural core: ends instructions and returns from routines.
// Assumes the unit's call request and a bench return command.
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Unit side
  input wire logic call_req_in,
  output logic boundary_out,
  output logic return_out,
  // Bench side
  input wire logic ret_cmd_in,
  input wire logic slow_in
);
  logic [1:0] cnt_reg;
  logic owe_reg;
  logic owe;
  ////////////////////////////////////////////////////////////////
  // Slow mode spaces instruction ends four clocks apart
  assign owe = owe_reg | ret_cmd_in;
  always @(negedge clock_in) begin
    boundary_out <= 1'b0;
    return_out <= 1'b0;
    owe_reg <= owe;
    if (rst_in) begin
      cnt_reg <= 2'h0;
      owe_reg <= 1'b0;
    end else if (cnt_reg == 2'h0) begin
      cnt_reg <= slow_in ? 2'h3 : 2'h0;
      // Return takes the next instruction slot
      if (owe) begin
        return_out <= 1'b1;
        owe_reg <= 1'b0;
      end else begin
        boundary_out <= 1'b1;
      end
    end else begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Bench for the vectored interrupt unit.
// Assumes the core model on the call side; bench drives flags.
`timescale 1ns/1ps
module tb_top;
  import irq_unit_pkg::*;
  logic clock_in, rst_in, sfr_wr_in, sfr_rd_in, ret_cmd, slow;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, ext_mask;
  logic [NUM_SOURCES-1:0] pending_in, priority_in, hw_clear_out;
  logic boundary, ret_done, call_req_out;
  logic [15:0] vector_out;
  logic [1:0] service_level_out;
  int n_errors, checks, k;

  two_level_vectored_interrupt_unit two_level_vectored_interrupt_unit_i (
    .clock_in, .rst_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in,
    .sfr_rd_in, .sfr_rdata_out, .pending_in, .priority_in,
    .extended_mask_register_in(ext_mask), .hw_clear_out,
    .instr_boundary_in(boundary), .return_from_service_in(ret_done),
    .call_req_out, .vector_out, .service_level_out);

  core_model core_model_i (.clock_in, .rst_in, .call_req_in(call_req_out),
    .boundary_out(boundary), .return_out(ret_done), .ret_cmd_in(ret_cmd),
    .slow_in(slow));

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    tick(1);
    sfr_wr_in <= 1'b0;
    tick(1);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    tick(1);
    sfr_rd_in <= 1'b0;
    check(sfr_rdata_out, exp);
    tick(1);
    check(sfr_rdata_out, 8'h00);
  endtask
  // Waits are bounded; the slow core needs up to four clocks a take
  task automatic serve(input int k, input logic [1:0] lvl);
    int i;
    for (i = 0; i < 4 && call_req_out !== 1'b1; i++) tick(1);
    check(call_req_out, 1'b1);
    if (call_req_out !== 1'b1) stop_test();
    check(vector_out, VECTOR_BASE + 16'(k << VECTOR_SHIFT));
    for (i = 0; i < 20 && call_req_out === 1'b1; i++) tick(1);
    if (call_req_out !== 1'b0) begin
      n_errors++;
      stop_test();
    end
    check(16'(i <= MAX_LATENCY_CYCLES), 16'h0001);
    check(hw_clear_out, k < 4 ? 15'h0001 << k : 15'h0000);
    check(service_level_out, lvl);
    pending_in[k] <= 1'b0;
    tick(1);
  endtask
  task automatic ret(input logic [1:0] lvl);
    int i;
    ret_cmd <= 1'b1;
    tick(1);
    ret_cmd <= 1'b0;
    for (i = 0; i < 20 && service_level_out !== lvl; i++) tick(1);
    check(service_level_out, lvl);
    if (service_level_out !== lvl) stop_test();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    {sfr_wr_in, sfr_rd_in, ret_cmd, slow} = 4'h0;
    {sfr_addr_in, sfr_wdata_in, ext_mask} = 24'h000000;
    pending_in = 15'h0000;
    priority_in = 15'h0000;
    n_errors = 0;
    checks = 0;
    tick(12);
    rst_in <= 1'b0;
    tick(1);
    reg_rd(8'hA8, PRIMARY_MASK_RESET);
    reg_wr(8'hA8, 8'h5A);
    reg_wr(8'hA9, 8'hFF);
    reg_rd(8'hA8, 8'h5A);
    reg_rd(8'hA9, 8'h00);
    $display("test registers done");
    pending_in <= 15'h7FFF;
    reg_wr(8'hA8, 8'h7F);
    tick(3);
    check(call_req_out, 1'b0);
    reg_wr(8'hA8, 8'h80);
    tick(3);
    check(call_req_out, 1'b0);
    pending_in <= 15'h0000;
    tick(2);
    $display("test gate done");
    for (k = 0; k < NUM_SOURCES; k++) begin
      reg_wr(8'hA8, k < 7 ? 8'h80 | (8'h01 << k) : 8'h80);
      ext_mask <= k < 7 ? 8'h00 : 8'h01 << (k - 7);
      pending_in <= 15'h0001 << k;
      tick(1);
      check(call_req_out, 1'b1);
      serve(k, 2'h1);
      ret(2'h0);
    end
    $display("test vectors done");
    // Slow core so the waiting requests overlap running routines
    slow <= 1'b1;
    ext_mask <= 8'h00;
    priority_in <= 15'h0002;
    reg_wr(8'hA8, 8'h9A);
    pending_in <= 15'h0008;
    tick(1);
    serve(3, 2'h1);
    pending_in[1] <= 1'b1;
    tick(1);
    serve(1, 2'h3);
    pending_in <= 15'h0018;
    tick(6);
    check(call_req_out, 1'b0);
    ret(2'h1);
    tick(4);
    check(call_req_out, 1'b0);
    ret(2'h0);
    serve(3, 2'h1);
    tick(4);
    check(call_req_out, 1'b0);
    ret(2'h0);
    serve(4, 2'h1);
    ret(2'h0);
    priority_in <= 15'h0020;
    reg_wr(8'hA8, 8'hA4);
    pending_in <= 15'h0024;
    tick(1);
    serve(5, 2'h2);
    ret(2'h0);
    serve(2, 2'h1);
    ret(2'h0);
    $display("test priority done");
    stop_test();
  end
endmodule
